// ==== rtl/gpsc_pkg.sv ====
// Shared constants and types for the four-port general-purpose I/O block.
// Assumes a 32-bit APB register bus with word-aligned register slots.
package gpsc_pkg;

    // Register indices; the byte address of each is four times its index.
    localparam logic [11:0] REG_PA_SUB_INDEX = 12'hfd0;
    localparam logic [11:0] REG_PA_SUB_WINDOW = 12'hfd1;
    localparam logic [11:0] REG_PA_PIN_LEVELS = 12'hfd2;
    localparam logic [11:0] REG_PA_DRIVE_LEVELS = 12'hfd3;
    localparam logic [11:0] REG_PB_SUB_INDEX = 12'hfd4;
    localparam logic [11:0] REG_PB_SUB_WINDOW = 12'hfd5;
    localparam logic [11:0] REG_PB_PIN_LEVELS = 12'hfd6;
    localparam logic [11:0] REG_PB_DRIVE_LEVELS = 12'hfd7;
    localparam logic [11:0] REG_PC_SUB_INDEX = 12'hfd8;
    localparam logic [11:0] REG_PC_SUB_WINDOW = 12'hfd9;
    localparam logic [11:0] REG_PC_PIN_LEVELS = 12'hfda;
    localparam logic [11:0] REG_PC_DRIVE_LEVELS = 12'hfdb;
    localparam logic [11:0] REG_PD_SUB_INDEX = 12'hfdc;
    localparam logic [11:0] REG_PD_SUB_WINDOW = 12'hfdd;
    localparam logic [11:0] REG_PD_RESERVED = 12'hfde;
    localparam logic [11:0] REG_PD_DRIVE_LEVELS = 12'hfdf;

    // Register kinds inside one port's group of four slots.
    localparam logic [1:0] KIND_SUB_INDEX = 2'h0;
    localparam logic [1:0] KIND_SUB_WINDOW = 2'h1;
    localparam logic [1:0] KIND_PIN_LEVELS = 2'h2;
    localparam logic [1:0] KIND_DRIVE_LEVELS = 2'h3;

    // Subregister index values seen through a port's window register.
    localparam logic [7:0] SUB_DIRECTION = 8'h01;
    localparam logic [7:0] SUB_ALT_ENABLE = 8'h02;
    localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] SUB_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] SUB_STOP_RECOVERY = 8'h05;
    localparam logic [7:0] SUB_PULLUP = 8'h06;
    localparam logic [7:0] SUB_ALT_SEL_ONE = 8'h07;
    localparam logic [7:0] SUB_ALT_SEL_TWO = 8'h08;

    // Reset values.
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PULLUP_PORT_D = 8'h01;
    localparam logic [7:0] RST_SMALL_PORT_A = 8'h04;

    // Implemented pins per port: 8 + 8 + 8 + 1 = 25.
    localparam logic [7:0] PIN_MASK_A = 8'hff;
    localparam logic [7:0] PIN_MASK_B = 8'hff;
    localparam logic [7:0] PIN_MASK_C = 8'hff;
    localparam logic [7:0] PIN_MASK_D = 8'h01;

    // One port's programmable state.
    typedef struct packed {
        logic [7:0] sub_index;
        logic [7:0] direction;
        logic [7:0] alt_enable;
        logic [7:0] open_drain;
        logic [7:0] high_drive;
        logic [7:0] stop_recovery;
        logic [7:0] pullup_enable;
        logic [7:0] altfunc_select_one;
        logic [7:0] altfunc_select_two;
        logic [7:0] drive_levels;
    } gpsc_port_cfg_t;

    // Pad-facing signals of one port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pin_pullup_on;
        logic [7:0] led_drive;
        logic [7:0] pin_altfunc_sel_one;
        logic [7:0] pin_altfunc_sel_two;
        logic [7:0] wake_enable;
    } gpsc_pad_t;

    // Decoded register address.
    typedef struct packed {
        logic hit;
        logic [1:0] port;
        logic [1:0] kind;
    } gpsc_dec_t;

    // Whole state of the register block.
    typedef struct packed {
        gpsc_port_cfg_t [3:0] port;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gpsc_state_t;

endpackage

// ==== rtl/gpsc_sync.sv ====
// Two-stage synchroniser for the port pin levels.
// Assumes its inputs are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module gpsc_sync #(
    parameter int W = 32
) (
    input wire logic pclk,  // System clock.
    input wire logic presetn,  // Asynchronous reset, active low.
    input wire logic [W-1:0] d,  // Asynchronous levels.
    output logic [W-1:0] q  // Synchronised levels.
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] held;
    } gpsc_sync_t;

    gpsc_sync_t s_q;
    gpsc_sync_t s_d;

    // The first stage is read by the second stage alone.
    always_comb begin
        s_d.meta = d;
        s_d.held = s_q.meta;
    end

    // Both stages clear under reset so the levels read as zero at first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.held;
endmodule
`default_nettype wire

// ==== rtl/gpsc_pad_drv.sv ====
// Pad driver for one eight-pin port: picks data and drive per pin.
// Assumes cfg comes from the register block on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gpsc_pad_drv
    import gpsc_pkg::*;
#(
    parameter logic [7:0] PIN_MASK = 8'hff,
    parameter bit LED_CAPABLE = 1'b0
) (
    input wire logic pclk,  // System clock.
    input wire logic presetn,  // Asynchronous reset, active low.
    input var gpsc_port_cfg_t cfg,  // Port configuration.
    input wire logic [7:0][3:0] alt_data,  // Alternate function outputs.
    output gpsc_pad_t pad_q  // Registered pad signals.
);
    gpsc_pad_t pad_d;
    logic [1:0] sel;
    logic data;
    logic drive;

    // Every pin is worked out on its own from its own control bits.
    always_comb begin
        pad_d = '0;
        sel = 2'h0;
        data = 1'b0;
        drive = 1'b0;
        for (int i = 0; i < 8; i++) begin
            sel = {cfg.altfunc_select_two[i], cfg.altfunc_select_one[i]};
            data = cfg.alt_enable[i] ? alt_data[i][sel] : cfg.drive_levels[i];
            // An open-drain pin only ever pulls low, so a high releases it.
            drive = !cfg.direction[i] && (!cfg.open_drain[i] || !data);
            pad_d.out[i] = data && PIN_MASK[i];
            pad_d.oe_n[i] = !(drive && PIN_MASK[i]);
            pad_d.pin_pullup_on[i] = cfg.pullup_enable[i] && PIN_MASK[i];
            pad_d.led_drive[i] = LED_CAPABLE && cfg.high_drive[i] && PIN_MASK[i];
            pad_d.pin_altfunc_sel_one[i] = cfg.alt_enable[i] && cfg.altfunc_select_one[i]
                && PIN_MASK[i];
            pad_d.pin_altfunc_sel_two[i] = cfg.alt_enable[i] && cfg.altfunc_select_two[i]
                && PIN_MASK[i];
            pad_d.wake_enable[i] = cfg.stop_recovery[i] && PIN_MASK[i];
        end
    end

    // Pads come up released until the configuration has been applied.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_q <= '{oe_n: 8'hff, default: 8'h00};
        end else begin
            pad_q <= pad_d;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/gpsc_gpio_port.sv ====
// Register block and pad control for four general-purpose I/O ports.
// Assumes an APB master on pclk, asynchronous pins and alternate sources on pclk.
//
// Functional notes
// - Index 06h makes a port's window register reach its pull-up enable subregister.
// - Index 07h makes the window reach the first alternate-function select subregister.
// - Index 08h makes the window reach the second alternate-function select subregister.
// - Each pull-up enable bit turns the weak pull-up of its own pin on when 1.
// - Pull-up enables reset to 00h on ports A to C, 01h on D, 04h on A when small.
// - Second select sets reset to 00h, except 04h on port A of the small variant.
// - Each first select bit picks the alternate function of its own pin.
// - Each second select bit joins the first to pick the function of its pin.
// - A pin shows its alternate function only while its alternate enable bit is set.
// - Every pin is configured on its own with one bit per pin in each setting.
// - Control subregisters set direction, open drain, drive, pull-up, wake and select.
// - At most 25 pins exist, spread over ports A to D.
// - Port C pins can drive LEDs directly with a software-chosen strength.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module gpsc_gpio_port
    import gpsc_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter logic [7:0] MASK_A = PIN_MASK_A,
    parameter logic [7:0] MASK_B = PIN_MASK_B,
    parameter logic [7:0] MASK_C = PIN_MASK_C,
    parameter logic [7:0] MASK_D = PIN_MASK_D
) (
    input wire logic pclk,  // System clock, 40 MHz.
    input wire logic presetn,  // Asynchronous reset, active low.
    input wire logic psel,  // APB select.
    input wire logic penable,  // APB access phase.
    input wire logic pwrite,  // APB direction, high for write.
    input wire logic [13:0] paddr,  // APB byte address.
    input wire logic [31:0] pwdata,  // APB write data.
    input wire logic [3:0] pstrb,  // APB write byte strobes.
    output logic [31:0] prdata,  // APB read data.
    output logic pready,  // APB ready.
    output logic pslverr,  // APB error for unmapped addresses.
    input wire logic [3:0][7:0] pin_in,  // Pad input levels, asynchronous.
    input wire logic [3:0][7:0][3:0] alt_data,  // Alternate function data per pin.
    output logic [3:0][7:0] pin_levels,  // Synchronised pad input levels.
    output gpsc_pad_t [3:0] pad  // Pad control per port.
);
    // Implemented pins per port; bits outside the mask read zero.
    localparam logic [3:0][7:0] MASK = {MASK_D, MASK_C, MASK_B, MASK_A};

    // Reset value of one port's configuration.
    function automatic gpsc_port_cfg_t cfg_reset(input int p);
        gpsc_port_cfg_t c;
        c = '0;
        c.sub_index = RST_ZERO;
        c.direction = RST_DIRECTION & MASK[p];
        c.alt_enable = RST_ZERO;
        c.open_drain = RST_ZERO;
        c.high_drive = RST_ZERO;
        c.stop_recovery = RST_ZERO;
        c.pullup_enable = (p == 3) ? RST_PULLUP_PORT_D : RST_ZERO;
        c.altfunc_select_one = RST_ZERO;
        c.altfunc_select_two = RST_ZERO;
        // The smallest package variant routes port A pin 2 differently at reset.
        if (SMALL_PACKAGE && p == 0) begin
            c.pullup_enable = RST_SMALL_PORT_A;
            c.altfunc_select_two = RST_SMALL_PORT_A;
        end
        c.drive_levels = RST_ZERO;
        return c;
    endfunction

    // Reset value of the whole block.
    function automatic gpsc_state_t state_reset();
        gpsc_state_t s;
        s = '0;
        for (int p = 0; p < 4; p++) begin
            s.port[p] = cfg_reset(p);
        end
        return s;
    endfunction

    localparam gpsc_state_t ST_RST = state_reset();

    // Address decode, shared by the read path and the write path.
    function automatic gpsc_dec_t reg_decode(input logic [13:0] a);
        gpsc_dec_t r;
        logic [11:0] idx;
        logic [11:0] off;
        idx = a[13:2];
        off = idx - REG_PA_SUB_INDEX;
        r.hit = (a[1:0] == 2'h0) && (idx >= REG_PA_SUB_INDEX)
            && (idx <= REG_PD_DRIVE_LEVELS) && (idx != REG_PD_RESERVED);
        r.port = off[3:2];
        r.kind = off[1:0];
        return r;
    endfunction

    // Window read: the subregister chosen by the port's index.
    function automatic logic [7:0] sub_read(input gpsc_port_cfg_t c);
        logic [7:0] v;
        v = 8'h00;
        case (c.sub_index)
            SUB_DIRECTION: v = c.direction;
            SUB_ALT_ENABLE: v = c.alt_enable;
            SUB_OPEN_DRAIN: v = c.open_drain;
            SUB_HIGH_DRIVE: v = c.high_drive;
            SUB_STOP_RECOVERY: v = c.stop_recovery;
            SUB_PULLUP: v = c.pullup_enable;
            SUB_ALT_SEL_ONE: v = c.altfunc_select_one;
            SUB_ALT_SEL_TWO: v = c.altfunc_select_two;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Window write: only the subregister chosen by the index changes.
    function automatic gpsc_port_cfg_t sub_write(input gpsc_port_cfg_t c,
            input logic [7:0] v);
        gpsc_port_cfg_t r;
        r = c;
        case (c.sub_index)
            SUB_DIRECTION: r.direction = v;
            SUB_ALT_ENABLE: r.alt_enable = v;
            SUB_OPEN_DRAIN: r.open_drain = v;
            SUB_HIGH_DRIVE: r.high_drive = v;
            SUB_STOP_RECOVERY: r.stop_recovery = v;
            SUB_PULLUP: r.pullup_enable = v;
            SUB_ALT_SEL_ONE: r.altfunc_select_one = v;
            SUB_ALT_SEL_TWO: r.altfunc_select_two = v;
            default: r = c;
        endcase
        return r;
    endfunction

    gpsc_state_t q;
    gpsc_state_t d;
    gpsc_dec_t dec;
    logic [3:0][7:0] level_q;
    logic access;
    logic commit;
    logic [7:0] rd_byte;
    logic [7:0] wr_pin;

    // Pin levels are asynchronous, so they pass two flip-flops first.
    gpsc_sync #(
        .W(32)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_in),
        .q(level_q)
    );

    // Register read multiplexer for the decoded slot.
    always_comb begin
        rd_byte = 8'h00;
        if (dec.hit) begin
            unique case (dec.kind)
                KIND_SUB_INDEX: rd_byte = q.port[dec.port].sub_index;
                KIND_SUB_WINDOW: rd_byte = sub_read(q.port[dec.port]);
                KIND_PIN_LEVELS: rd_byte = level_q[dec.port] & MASK[dec.port];
                KIND_DRIVE_LEVELS: rd_byte = q.port[dec.port].drive_levels;
            endcase
        end
    end

    // Bus slave. The first access cycle prepares the answer and raises
    // pready; the write lands on the edge that samples pready high. This
    // costs one wait state but keeps every bus output on a flip-flop.
    always_comb begin
        d = q;
        dec = reg_decode(paddr);
        access = psel && penable;
        commit = access && q.pready && dec.hit && pwrite && pstrb[0];
        // Only pin bits that exist are writable, so absent pins read zero.
        wr_pin = pwdata[7:0] & MASK[dec.port];
        d.pready = 1'b0;
        if (access && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !dec.hit;
            d.prdata = (dec.hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end else if (!access) begin
            d.pslverr = 1'b0;
            d.prdata = 32'h00000000;
        end
        if (commit) begin
            unique case (dec.kind)
                KIND_SUB_INDEX: begin
                    d.port[dec.port].sub_index = pwdata[7:0];
                end
                KIND_SUB_WINDOW: begin
                    d.port[dec.port] = sub_write(q.port[dec.port], wr_pin);
                end
                KIND_PIN_LEVELS: begin
                    d.port[dec.port] = q.port[dec.port];
                end
                KIND_DRIVE_LEVELS: begin
                    d.port[dec.port].drive_levels = wr_pin;
                end
            endcase
        end
    end

    // All block state in one register; reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // One pad driver per port; only port C has the LED drive stage.
    for (genvar p = 0; p < 4; p++) begin : g_port
        gpsc_pad_drv #(
            .PIN_MASK(MASK[p]),
            .LED_CAPABLE(p == 2)
        ) u_pad (
            .pclk(pclk),
            .presetn(presetn),
            .cfg(q.port[p]),
            .alt_data(alt_data[p]),
            .pad_q(pad[p])
        );
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign pin_levels = level_q;
endmodule
`default_nettype wire

// ==== dv/gpsc_gpio_port_asserts.sv ====
// Port-level checks for the four-port I/O register block.
// Assumes binding to gpsc_gpio_port with its default pin masks.
`timescale 1ns/1ps
`default_nettype none
module gpsc_gpio_port_asserts
    import gpsc_pkg::*;
(
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic [13:0] paddr, // Byte address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic [3:0][7:0] pin_in, // Pad levels.
    input wire logic [3:0][7:0] pin_levels, // Synchronised levels.
    input var gpsc_pad_t [3:0] pad // Pad control.
);
    logic [1:0] settle_q;

    // Edges since reset; the synchroniser is judged only once it has filled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_q <= 2'h0;
        end else if (settle_q != 2'h3) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    property p_one_wait;
        s_access |=> s_answer;
    endproperty
    property p_upper_zero;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    property p_reserved_err;
        (psel && penable && !pready && paddr[13:2] == REG_PD_RESERVED)
            |=> pslverr && prdata == 32'h0;
    endproperty
    property p_misaligned_err;
        (psel && penable && !pready && paddr[1:0] != 2'h0) |=> pready && pslverr;
    endproperty
    property p_pin_sync;
        settle_q == 2'h3 |-> pin_levels[2:0] == $past(pin_in[2:0], 2);
    endproperty
    property p_pins_absent;
        pad[3].oe_n[7:1] == 7'h7f && pad[3].out[7:1] == 7'h0;
    endproperty
    property p_led_c_only;
        pad[0].led_drive == 8'h0 && pad[1].led_drive == 8'h0 && pad[3].led_drive == 8'h0;
    endproperty
    property p_reset_pullups;
        $rose(presetn) |=> pad[3].pin_pullup_on == 8'h01 && pad[0].pin_pullup_on == 8'h00;
    endproperty

    a_one_wait: assert property (p_one_wait) else $error("pready not one wait state");
    a_upper_zero: assert property (p_upper_zero) else $error("prdata upper bits set");
    a_reserved_err: assert property (p_reserved_err) else $error("reserved slot");
    a_misaligned_err: assert property (p_misaligned_err) else $error("misaligned");
    a_pin_sync: assert property (p_pin_sync) else $error("pin levels lag");
    a_pins_absent: assert property (p_pins_absent) else $error("absent pin active");
    a_led_c_only: assert property (p_led_c_only) else $error("led drive off port C");
    a_reset_pullups: assert property (p_reset_pullups) else $error("reset pull-ups");
endmodule
`default_nettype wire

// ==== dv/gpsc_pin_model.sv ====
// Circuitry on the port pins: external drivers, pull-ups and floating lines.
// Assumes pad comes straight from the block and the ext inputs from the bench.
`timescale 1ns/1ps
`default_nettype none
module gpsc_pin_model
    import gpsc_pkg::*;
(
    input wire logic pclk, // Clock for the floating pattern.
    input var gpsc_pad_t [3:0] pad, // Pad control from the block.
    input wire logic [3:0][7:0] ext_en, // External driver on, per pin.
    input wire logic [3:0][7:0] ext_val, // External driven level.
    output logic [3:0][7:0] pin_in // Resolved pin levels.
);
    logic [7:0] float_q = 8'h55;

    // A floating line toggles, so a read that leans on it cannot pass by luck.
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end

    // Block drive wins, then an external driver, then the weak pull-up.
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 8; i++) begin
                if (!pad[p].oe_n[i]) pin_in[p][i] = pad[p].out[i];
                else if (ext_en[p][i]) pin_in[p][i] = ext_val[p][i];
                else if (pad[p].pin_pullup_on[i]) pin_in[p][i] = 1'b1;
                else pin_in[p][i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/gpsc_gpio_port_tb.sv ====
// Self-checking bench for the four-port I/O register block.
// Assumes default pin masks and the pin model standing on the pads.
`timescale 1ns/1ps
`default_nettype none
module gpsc_gpio_port_tb;
    import gpsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [3:0][7:0] pin_in, pin_levels, ext_en, ext_val;
    logic [3:0][7:0][3:0] alt_data;
    gpsc_pad_t [3:0] pad;
    logic [7:0] rd;
    int mismatches, n_compared;

    gpsc_gpio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .alt_data(alt_data),
        .pin_levels(pin_levels), .pad(pad));
    gpsc_pin_model pins_u (.pclk(pclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // Clock at 40 MHz.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer, held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [13:0] a, input logic [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            mismatches++;
            print_verdict();
        end
    endtask

    function automatic logic [13:0] ra(input int p, input logic [1:0] k);
        return {REG_PA_SUB_INDEX + 12'(4 * p) + 12'(k), 2'b00};
    endfunction

    // Index write then window write: the two-step subregister access.
    task automatic sub_wr(input int p, input logic [7:0] s, input logic [7:0] d);
        apb(1'b1, ra(p, KIND_SUB_INDEX), s);
        apb(1'b1, ra(p, KIND_SUB_WINDOW), d);
    endtask
    task automatic sub_rd(input int p, input logic [7:0] s);
        apb(1'b1, ra(p, KIND_SUB_INDEX), s);
        apb(1'b0, ra(p, KIND_SUB_WINDOW), 8'h00);
    endtask

    task automatic reset_values();
        for (int p = 0; p < 4; p++) begin
            sub_rd(p, SUB_PULLUP);
            check(rd, (p == 3) ? 8'h01 : 8'h00);
            sub_rd(p, SUB_ALT_SEL_ONE);
            check(rd, 8'h00);
            sub_rd(p, SUB_ALT_SEL_TWO);
            check(rd, 8'h00);
        end
    endtask

    // Port B: each index reaches its own subregister; alt outputs wait for enable.
    task automatic window_select();
        sub_wr(1, SUB_PULLUP, 8'h5a);
        sub_wr(1, SUB_ALT_SEL_ONE, 8'ha5);
        sub_wr(1, SUB_ALT_SEL_TWO, 8'h3c);
        check(pad[1].pin_pullup_on, 8'h5a);
        check(pad[1].pin_altfunc_sel_one, 8'h00);
        sub_rd(1, SUB_PULLUP);
        check(rd, 8'h5a);
        sub_rd(1, SUB_ALT_SEL_ONE);
        check(rd, 8'ha5);
        sub_rd(1, SUB_ALT_SEL_TWO);
        check(rd, 8'h3c);
        sub_rd(1, 8'h09);
        check(rd, 8'h00);
        sub_wr(1, SUB_DIRECTION, 8'h00);
        sub_wr(1, SUB_ALT_ENABLE, 8'hff);
        repeat (2) @(posedge pclk);
        check(pad[1].pin_altfunc_sel_one, 8'ha5);
        check(pad[1].pin_altfunc_sel_two, 8'h3c);
        check(pad[1].out, 8'h18);
    endtask

    // Single-pin port D and per-pin pull-ups on port A.
    task automatic per_pin();
        sub_wr(3, SUB_PULLUP, 8'hff);
        sub_rd(3, SUB_PULLUP);
        check(rd, 8'h01);
        sub_wr(0, SUB_PULLUP, 8'h81);
        // The pads are registered, so they follow the write one edge later.
        repeat (2) @(posedge pclk);
        check(pad[0].pin_pullup_on, 8'h81);
    endtask

    // Pins seen back through the levels registers, pulled, driven and output.
    task automatic pin_paths();
        sub_wr(0, SUB_PULLUP, 8'hf0);
        ext_en[0] <= 8'h0f;
        ext_val[0] <= 8'h05;
        sub_wr(2, SUB_DIRECTION, 8'h00);
        apb(1'b1, ra(2, KIND_DRIVE_LEVELS), 8'h3c);
        sub_wr(2, SUB_HIGH_DRIVE, 8'h0f);
        repeat (4) @(posedge pclk);
        check(pad[2].led_drive, 8'h0f);
        apb(1'b0, ra(0, KIND_PIN_LEVELS), 8'h00);
        check(rd, 8'hf5);
        apb(1'b0, ra(2, KIND_PIN_LEVELS), 8'h00);
        check(rd, 8'h3c);
        // Open drain on the low nibble releases the pins that output a high.
        sub_wr(2, SUB_OPEN_DRAIN, 8'h0f);
        sub_wr(2, SUB_STOP_RECOVERY, 8'h81);
        repeat (2) @(posedge pclk);
        check(pad[2].oe_n, 8'h0c);
        check(pad[2].wake_enable, 8'h81);
    endtask

    // Reserved slot and misaligned address both answer with an error.
    task automatic refusals();
        apb(1'b0, {REG_PD_RESERVED, 2'b00}, 8'h00);
        check(err, 1'b1);
        check(rd, 8'h00);
        apb(1'b1, ra(0, KIND_SUB_INDEX) | 14'h2, 8'h06);
        check(err, 1'b1);
        // A write without its low byte strobe must leave the register alone.
        pstrb <= 4'he;
        apb(1'b1, ra(0, KIND_DRIVE_LEVELS), 8'hff);
        pstrb <= 4'hf;
        apb(1'b0, ra(0, KIND_DRIVE_LEVELS), 8'h00);
        check(rd, 8'h00);
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        mismatches = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        ext_en = '0;
        ext_val = '0;
        alt_data = {32{4'h4}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        window_select();
        per_pin();
        pin_paths();
        refusals();
        print_verdict();
    end
endmodule

bind gpsc_gpio_port gpsc_gpio_port_asserts chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_levels(pin_levels), .pad(pad));
`default_nettype wire
